// ==== core/clk_cfg_pkg.sv ====
package clk_cfg_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFF_RESET_ID_LOW = 8'h00;
  localparam logic [7:0] OFF_ID_HIGH = 8'h01;
  localparam logic [7:0] OFF_REVISION = 8'h02;
  localparam logic [7:0] OFF_FRAC_LOW = 8'h03;
  localparam logic [7:0] OFF_FRAC_MID = 8'h04;
  localparam logic [7:0] OFF_FRAC_HIGH = 8'h05;
  localparam logic [7:0] OFF_INT_PRE_VAL = 8'h06;
  localparam logic [7:0] OFF_DIVIDERS = 8'h07;
  localparam logic [7:0] OFF_SRC_FILL = 8'h08;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [7:0] RST_FRAC_LOW = 8'h21;
  localparam logic [7:0] RST_FRAC_MID = 8'hFD;
  localparam logic [5:0] RST_FRAC_HIGH = 6'h36;
  localparam logic [7:0] RST_INT_PRE_VAL = 8'h07;
  localparam logic [7:0] RST_DIVIDERS = 8'h16;
  localparam logic [7:0] RST_SRC_FILL = 8'h18;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int INT_RATIO_LSB = 0;
  localparam int INPUT_HALVER_BIT = 4;
  localparam int TX_VALID_SUB0_BIT = 5;
  localparam int TX_VALID_SUB1_BIT = 6;
  localparam int TX_VALID_FORCE_BIT = 7;
  localparam int POST_DIV_LSB = 0;
  localparam int FRAC_MODE_BIT = 2;
  localparam int MASTER_DIV_BIT = 3;
  localparam int AUX_DIV_LSB = 4;
  localparam int AUX_SRC_BIT = 3;
  localparam int AUX_PIN_EN_BIT = 4;
  localparam int FILL_SEL_BIT = 5;
  localparam int IGNORE_INVALID_BIT = 6;
  localparam int MASTER_SRC_BIT = 7;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int SAMPLE_W = 24;
  localparam int AUX_DIV_CNT_W = 3;

  typedef enum logic [1:0] {
    SW_PARK,
    SW_ON0,
    SW_ON1
  } switch_state_t;

endpackage

// ==== core/clean_clock_switch.sv ====
`timescale 1ns/100ps
module clean_clock_switch
  import clk_cfg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sources, sampled levels
  input wire logic src0,
  input wire logic src1,
  input wire logic sel,
  // Output
  output logic clk_out
);

  switch_state_t state;
  switch_state_t next_state;
  logic next_clk_out;

  // Leave a source only while it is low, join the next only while
  // it is low, so every high phase on the output is a whole one
  always_comb
  begin
    next_state = state;
    next_clk_out = 1'b0;
    case (state)
      SW_PARK:
      begin
        if (!sel && !src0)
          next_state = SW_ON0;
        else if (sel && !src1)
          next_state = SW_ON1;
      end
      SW_ON0:
      begin
        next_clk_out = src0;
        if (sel && !src0)
        begin
          next_state = SW_PARK;
          next_clk_out = 1'b0;
        end
      end
      SW_ON1:
      begin
        next_clk_out = src1;
        if (!sel && !src1)
        begin
          next_state = SW_PARK;
          next_clk_out = 1'b0;
        end
      end
      default:
        next_state = SW_PARK;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= SW_PARK;
      clk_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      clk_out <= next_clk_out;
    end
  end

  property p_park_low;
    @(posedge sys_clk) disable iff (rst)
    (state == SW_PARK) |=> (state != SW_PARK) || !clk_out;
  endproperty
  a_park_low: assert property (p_park_low) // RL23
    else $error("switch output high while parked");

endmodule

// ==== core/pll_clock_config_regs.sv ====
// Function
// RL1: Any write to offset zero resets the whole device, data ignored.
// RL2: Offsets zero and one return the two bytes of a fixed identity code.
// RL3: Fractional ratio is one 22-bit value over offsets three to five.
// RL4: Software keeps integer ratio within 5 to 13; resets to 0111.
// RL5: Software loads required ratio values when the receiver is used.
// RL6: Input halver bit feeds PLL oscillator divided by one or two.
// RL7: Forced validity sends sub0 and sub1 bits from the register.
// RL8: Unforced validity is zero from PCM, copied when fed from receiver.
// RL9: Fraction mode bit clear uses integer ratio only; resets to one.
// RL10: Software keeps fraction mode on while receiving.
// RL11: Post divider field selects PLL output divider; resets to 10.
// RL12: In receive mode the post divider is set by the device itself.
// RL13: Master clock divider acts only when PLL clock b is selected.
// RL14: Aux divider acts only when PLL clock a is the aux source.
// RL15: Aux source bit picks PLL clock a or oscillator; resets to one.
// RL16: Aux pin enable bit tristates or drives the pin; resets to one.
// RL17: Bad input holds last valid sample or outputs zeros, by fill bit.
// RL18: Ignore-invalid bit makes the receiver disregard the invalid flag.
// RL19: Master source bit picks PLL clock b or oscillator; resets to zero.
// RL20: Only identity registers return data; the rest are write-only.
// RL21: Software writes zero into every unused register bit.
// RL22: A reset by write to offset zero restores all default values.
// RL23: Clock source changes produce no runt pulses on clock outputs.
`timescale 1ns/100ps
module pll_clock_config_regs
  import clk_cfg_pkg::*;
#(
  // Identity values are arbitrary
  parameter logic [15:0] ID_CODE = 16'h3C5A,
  parameter logic [3:0] REV_CODE = 4'h1
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic dev_reset_pulse,
  // Clock sources
  input wire logic osc_clk_a,
  input wire logic pll_clk_a,
  input wire logic pll_clk_b,
  // PLL settings
  input wire logic rx_mode,
  input wire logic [1:0] rx_auto_post_div,
  output logic pll_ref_clk,
  output logic [3:0] pll_int_ratio,
  output logic [21:0] pll_frac_ratio,
  output logic [1:0] pll_post_div,
  // Clock outputs
  output logic master_clk_out,
  output logic aux_clk_out,
  output logic aux_clk_out_oe_n,
  // Transmit validity
  input wire logic tx_from_rx,
  input wire logic tx_subframe,
  input wire logic rx_validity,
  output logic tx_validity,
  // Receiver fill
  input wire logic [SAMPLE_W-1:0] rx_sample,
  input wire logic rx_sample_stb,
  input wire logic rx_corrupt,
  input wire logic rx_invalid,
  output logic [SAMPLE_W-1:0] rx_data
);

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [7:0] pll_frac_low;
  logic [7:0] pll_frac_mid;
  logic [5:0] pll_frac_high;
  logic [7:0] pll_int_input_halver_validity;
  logic [7:0] pll_dividers;
  logic [7:0] clock_source_fill;
  logic [7:0] next_pll_frac_low;
  logic [7:0] next_pll_frac_mid;
  logic [5:0] next_pll_frac_high;
  logic [7:0] next_pll_int_input_halver_validity;
  logic [7:0] next_pll_dividers;
  logic [7:0] next_clock_source_fill;
  logic [7:0] next_reg_rdata;
  logic next_dev_reset_pulse;
  logic soft_reset;

  assign soft_reset = reg_wr && (reg_addr == OFF_RESET_ID_LOW);

  // Unused bits are not stored, so stray ones never reach the logic
  always_comb
  begin
    next_pll_frac_low = pll_frac_low;
    next_pll_frac_mid = pll_frac_mid;
    next_pll_frac_high = pll_frac_high;
    next_pll_int_input_halver_validity = pll_int_input_halver_validity;
    next_pll_dividers = pll_dividers;
    next_clock_source_fill = clock_source_fill;
    next_dev_reset_pulse = soft_reset; // RL1
    if (soft_reset)
    begin
      next_pll_frac_low = RST_FRAC_LOW; // RL22
      next_pll_frac_mid = RST_FRAC_MID;
      next_pll_frac_high = RST_FRAC_HIGH;
      next_pll_int_input_halver_validity = RST_INT_PRE_VAL;
      next_pll_dividers = RST_DIVIDERS;
      next_clock_source_fill = RST_SRC_FILL;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFF_FRAC_LOW: next_pll_frac_low = reg_wdata; // RL3
        OFF_FRAC_MID: next_pll_frac_mid = reg_wdata; // RL3
        OFF_FRAC_HIGH: next_pll_frac_high = reg_wdata[5:0]; // RL3
        OFF_INT_PRE_VAL: next_pll_int_input_halver_validity = reg_wdata;
        OFF_DIVIDERS: next_pll_dividers = {2'b00, reg_wdata[5:0]};
        OFF_SRC_FILL: next_clock_source_fill = {reg_wdata[7:3], 3'b000};
        default: next_pll_frac_low = pll_frac_low;
      endcase
    end
  end

  // Read answer one cycle after the strobe; write-only reads as zero
  always_comb
  begin
    next_reg_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_RESET_ID_LOW: next_reg_rdata = ID_CODE[7:0]; // RL2
        OFF_ID_HIGH: next_reg_rdata = ID_CODE[15:8]; // RL2
        OFF_REVISION: next_reg_rdata = {4'h0, REV_CODE};
        default: next_reg_rdata = 8'h00; // RL20
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pll_frac_low <= RST_FRAC_LOW;
      pll_frac_mid <= RST_FRAC_MID;
      pll_frac_high <= RST_FRAC_HIGH;
      pll_int_input_halver_validity <= RST_INT_PRE_VAL; // RL4
      pll_dividers <= RST_DIVIDERS; // RL11
      clock_source_fill <= RST_SRC_FILL;
      reg_rdata <= 8'h00;
      dev_reset_pulse <= 1'b0;
    end
    else
    begin
      pll_frac_low <= next_pll_frac_low;
      pll_frac_mid <= next_pll_frac_mid;
      pll_frac_high <= next_pll_frac_high;
      pll_int_input_halver_validity <= next_pll_int_input_halver_validity;
      pll_dividers <= next_pll_dividers;
      clock_source_fill <= next_clock_source_fill;
      reg_rdata <= next_reg_rdata;
      dev_reset_pulse <= next_dev_reset_pulse;
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  logic input_halver;
  logic tx_valid_sub0;
  logic tx_valid_sub1;
  logic tx_valid_force_en;
  logic [1:0] post_div_sel;
  logic frac_mode_en;
  logic master_clk_div_sel;
  logic [1:0] aux_out_div_sel;
  logic aux_out_src_sel;
  logic aux_out_pin_en;
  logic error_fill_sel;
  logic ignore_invalid;
  logic master_clk_src_sel;

  assign input_halver = pll_int_input_halver_validity[INPUT_HALVER_BIT];
  assign tx_valid_sub0 = pll_int_input_halver_validity[TX_VALID_SUB0_BIT];
  assign tx_valid_sub1 = pll_int_input_halver_validity[TX_VALID_SUB1_BIT];
  assign tx_valid_force_en = pll_int_input_halver_validity[TX_VALID_FORCE_BIT];
  assign post_div_sel = pll_dividers[POST_DIV_LSB +: 2];
  assign frac_mode_en = pll_dividers[FRAC_MODE_BIT];
  assign master_clk_div_sel = pll_dividers[MASTER_DIV_BIT];
  assign aux_out_div_sel = pll_dividers[AUX_DIV_LSB +: 2];
  assign aux_out_src_sel = clock_source_fill[AUX_SRC_BIT];
  assign aux_out_pin_en = clock_source_fill[AUX_PIN_EN_BIT];
  assign error_fill_sel = clock_source_fill[FILL_SEL_BIT];
  assign ignore_invalid = clock_source_fill[IGNORE_INVALID_BIT];
  assign master_clk_src_sel = clock_source_fill[MASTER_SRC_BIT];

  // ************************************************************
  // PLL settings and dividers
  // ************************************************************
  logic osc_prev;
  logic osc_half;
  logic pll_a_prev;
  logic pll_b_prev;
  logic pll_b_half;
  logic [AUX_DIV_CNT_W-1:0] aux_div_cnt;
  logic next_osc_half;
  logic next_pll_b_half;
  logic [AUX_DIV_CNT_W-1:0] next_aux_div_cnt;
  logic next_pll_ref_clk;
  logic [21:0] next_pll_frac_ratio;
  logic [1:0] next_pll_post_div;
  logic aux_pll_div;
  logic master_pll_div;

  always_comb
  begin
    next_osc_half = osc_half ^ (osc_clk_a && !osc_prev);
    next_pll_b_half = pll_b_half ^ (pll_clk_b && !pll_b_prev);
    next_aux_div_cnt = aux_div_cnt;
    if (pll_clk_a && !pll_a_prev)
      next_aux_div_cnt = aux_div_cnt + 3'd1;
    next_pll_ref_clk = input_halver ? osc_half : osc_clk_a; // RL6
    next_pll_frac_ratio = 22'h000000; // RL9
    if (frac_mode_en)
      next_pll_frac_ratio = {pll_frac_high, pll_frac_mid, pll_frac_low};
    next_pll_post_div = rx_mode ? rx_auto_post_div : post_div_sel; // RL12
  end

  // Dividers only reach the pins through the source muxes below
  always_comb
  begin
    case (aux_out_div_sel) // RL14
      2'b00: aux_pll_div = pll_clk_a;
      2'b01: aux_pll_div = aux_div_cnt[0];
      2'b10: aux_pll_div = aux_div_cnt[1];
      default: aux_pll_div = aux_div_cnt[2];
    endcase
    master_pll_div = master_clk_div_sel ? pll_b_half : pll_clk_b; // RL13
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_prev <= 1'b0;
      osc_half <= 1'b0;
      pll_a_prev <= 1'b0;
      pll_b_prev <= 1'b0;
      pll_b_half <= 1'b0;
      aux_div_cnt <= '0;
      pll_ref_clk <= 1'b0;
      pll_frac_ratio <= 22'h000000;
      pll_post_div <= 2'b00;
    end
    else
    begin
      osc_prev <= osc_clk_a;
      osc_half <= next_osc_half;
      pll_a_prev <= pll_clk_a;
      pll_b_prev <= pll_clk_b;
      pll_b_half <= next_pll_b_half;
      aux_div_cnt <= next_aux_div_cnt;
      pll_ref_clk <= next_pll_ref_clk;
      pll_frac_ratio <= next_pll_frac_ratio;
      pll_post_div <= next_pll_post_div;
    end
  end

  assign pll_int_ratio = pll_int_input_halver_validity[INT_RATIO_LSB +: 4];

  // ************************************************************
  // Clock outputs
  // ************************************************************
  clean_clock_switch u_master_switch (
    .sys_clk(sys_clk),
    .rst(rst),
    .src0(master_pll_div),
    .src1(osc_clk_a),
    .sel(master_clk_src_sel), // RL19
    .clk_out(master_clk_out)
  );

  clean_clock_switch u_aux_switch (
    .sys_clk(sys_clk),
    .rst(rst),
    .src0(aux_pll_div),
    .src1(osc_clk_a),
    .sel(aux_out_src_sel), // RL15
    .clk_out(aux_clk_out)
  );

  assign aux_clk_out_oe_n = !aux_out_pin_en; // RL16

  // ************************************************************
  // Transmit validity and receiver fill
  // ************************************************************
  logic next_tx_validity;
  logic [SAMPLE_W-1:0] next_rx_data;
  logic rx_bad;

  assign rx_bad = rx_corrupt || (rx_invalid && !ignore_invalid); // RL18

  always_comb
  begin
    if (tx_valid_force_en)
      next_tx_validity = tx_subframe ? tx_valid_sub1 : tx_valid_sub0; // RL7
    else
      next_tx_validity = tx_from_rx && rx_validity; // RL8
    next_rx_data = rx_data;
    if (rx_sample_stb)
    begin
      if (!rx_bad)
        next_rx_data = rx_sample;
      else if (error_fill_sel)
        next_rx_data = '0; // RL17
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_validity <= 1'b0;
      rx_data <= '0;
    end
    else
    begin
      tx_validity <= next_tx_validity;
      rx_data <= next_rx_data;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_soft_reset;
    @(posedge sys_clk) disable iff (rst)
    soft_reset |=> (pll_dividers == RST_DIVIDERS)
      && (clock_source_fill == RST_SRC_FILL) && dev_reset_pulse
      && ({pll_frac_high, pll_frac_mid} == {RST_FRAC_HIGH, RST_FRAC_MID});
  endproperty
  a_soft_reset: assert property (p_soft_reset) // RL1
    else $error("write to offset zero did not restore defaults");

  property p_id_read;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == OFF_ID_HIGH) |=> reg_rdata == ID_CODE[15:8];
  endproperty
  a_id_read: assert property (p_id_read) // RL2
    else $error("identity high byte wrong");

  property p_wo_read;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr > OFF_REVISION) |=> reg_rdata == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) // RL20
    else $error("write-only register returned data");

  property p_frac_path;
    @(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_FRAC_MID && frac_mode_en)
      ##1 frac_mode_en[*2]
      |-> pll_frac_ratio[15:8] == $past(reg_wdata, 2);
  endproperty
  a_frac_path: assert property (p_frac_path) // RL3
    else $error("fraction byte did not reach the PLL");

  property p_int_mode;
    @(posedge sys_clk) disable iff (rst)
    !frac_mode_en |=> pll_frac_ratio == 22'h000000;
  endproperty
  a_int_mode: assert property (p_int_mode) // RL9
    else $error("fraction used in integer mode");

  property p_rx_post_div;
    @(posedge sys_clk) disable iff (rst)
    rx_mode |=> pll_post_div == $past(rx_auto_post_div);
  endproperty
  a_rx_post_div: assert property (p_rx_post_div) // RL12
    else $error("post divider not set by device in receive mode");

  property p_force_valid;
    @(posedge sys_clk) disable iff (rst)
    (tx_valid_force_en && tx_subframe) |=> tx_validity == $past(tx_valid_sub1);
  endproperty
  a_force_valid: assert property (p_force_valid) // RL7
    else $error("forced sub1 validity not sent");

  property p_pcm_valid;
    @(posedge sys_clk) disable iff (rst)
    (!tx_valid_force_en && !tx_from_rx) |=> !tx_validity;
  endproperty
  a_pcm_valid: assert property (p_pcm_valid) // RL8
    else $error("validity not zero from PCM source");

  property p_fill_zero;
    @(posedge sys_clk) disable iff (rst)
    (rx_sample_stb && rx_bad && error_fill_sel) |=> rx_data == '0;
  endproperty
  a_fill_zero: assert property (p_fill_zero) // RL17
    else $error("bad sample not replaced by zeros");

  property p_fill_hold;
    @(posedge sys_clk) disable iff (rst)
    (rx_sample_stb && rx_corrupt && !error_fill_sel) |=> $stable(rx_data);
  endproperty
  a_fill_hold: assert property (p_fill_hold) // RL17
    else $error("bad sample did not hold last value");

  property p_ignore_invalid;
    @(posedge sys_clk) disable iff (rst)
    (rx_sample_stb && ignore_invalid && !rx_corrupt)
      |=> rx_data == $past(rx_sample);
  endproperty
  a_ignore_invalid: assert property (p_ignore_invalid) // RL18
    else $error("invalid flag not ignored");

  property p_pin_off;
    @(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == OFF_SRC_FILL && !reg_wdata[AUX_PIN_EN_BIT])
      |=> aux_clk_out_oe_n;
  endproperty
  a_pin_off: assert property (p_pin_off) // RL16
    else $error("aux pin driven while disabled");

endmodule

// ==== tb/pll_clock_config_regs_tb.sv ====
`timescale 1ns/100ps
module pll_clock_config_regs_tb
  import clk_cfg_pkg::*;
();
  // Identity values are arbitrary
  localparam logic [15:0] T_ID = 16'hA5C3;
  localparam logic [3:0] T_REV = 4'h6;
  logic sys_clk, rst, reg_wr, reg_rd, dev_reset_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic osc_clk_a, pll_clk_a, pll_clk_b, rx_mode, pll_ref_clk;
  logic [1:0] rx_auto_post_div, pll_post_div;
  logic [3:0] pll_int_ratio;
  logic [21:0] pll_frac_ratio;
  logic master_clk_out, aux_clk_out, aux_clk_out_oe_n;
  logic tx_from_rx, tx_subframe, rx_validity, tx_validity;
  logic [SAMPLE_W-1:0] rx_sample, rx_data, last_good, exp_d;
  logic rx_sample_stb, rx_corrupt, rx_invalid;
  int mismatches, checks_done, cycles, ph;
  int cnt [6];
  logic [5:0] prev_lv, cur_lv;

  pll_clock_config_regs #(.ID_CODE(T_ID), .REV_CODE(T_REV)) DUT (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dev_reset_pulse(dev_reset_pulse),
    .osc_clk_a(osc_clk_a), .pll_clk_a(pll_clk_a), .pll_clk_b(pll_clk_b),
    .rx_mode(rx_mode), .rx_auto_post_div(rx_auto_post_div),
    .pll_ref_clk(pll_ref_clk), .pll_int_ratio(pll_int_ratio),
    .pll_frac_ratio(pll_frac_ratio), .pll_post_div(pll_post_div),
    .master_clk_out(master_clk_out), .aux_clk_out(aux_clk_out),
    .aux_clk_out_oe_n(aux_clk_out_oe_n), .tx_from_rx(tx_from_rx),
    .tx_subframe(tx_subframe), .rx_validity(rx_validity),
    .tx_validity(tx_validity), .rx_sample(rx_sample),
    .rx_sample_stb(rx_sample_stb), .rx_corrupt(rx_corrupt),
    .rx_invalid(rx_invalid), .rx_data(rx_data)
  );

  // ************************************************************
  // Clock, sources and edge counters
  // ************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Sources stay well below half the sampling clock
  always @(negedge sys_clk)
  begin
    cur_lv = {aux_clk_out, master_clk_out, pll_ref_clk,
              pll_clk_b, pll_clk_a, osc_clk_a};
    for (int k = 0; k < 6; k++)
      if (cur_lv[k] === 1'b1 && prev_lv[k] === 1'b0)
        cnt[k]++;
    prev_lv = cur_lv;
    ph++;
    if (ph % 4 == 0)
      osc_clk_a = ~osc_clk_a;
    if (ph % 3 == 0)
      pll_clk_a = ~pll_clk_a;
    if (ph % 5 == 0)
      pll_clk_b = ~pll_clk_b;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      close_out();
    end
  end

  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  task automatic close_out();
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Counts drift by up to two around switch-over and sampling phase
  task automatic chk_near(input int got, input int exp);
    checks_done++;
    if (got > exp + 2 || got < exp - 2)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == OFF_RESET_ID_LOW)
      return T_ID[7:0];
    if (a == OFF_ID_HIGH)
      return T_ID[15:8];
    if (a == OFF_REVISION)
      return {4'h0, T_REV};
    return 8'h00;
  endfunction

  function automatic logic exp_valid(input logic [7:0] f);
    if (f[7])
      return f[1] ? f[6] : f[5];
    return f[0] ? f[2] : 1'b0;
  endfunction

  task automatic chk_defaults();
    chk(pll_int_ratio, RST_INT_PRE_VAL[3:0]);
    chk(pll_frac_ratio, {RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW});
    chk(pll_post_div, 2'b10);
    chk(aux_clk_out_oe_n, 1'b0);
  endtask

  task automatic measure(input int i);
    int c0 [6];
    int d [6];
    logic hv, ms, md, as;
    int dv;
    hv = i[1];
    ms = i[0];
    md = i[2];
    as = (i == 7);
    dv = i % 4;
    wr(OFF_INT_PRE_VAL, {3'b000, hv, 4'h8});
    wr(OFF_DIVIDERS, {2'b00, dv[1:0], md, 1'b1, 2'b10});
    wr(OFF_SRC_FILL, {ms, 2'b00, 1'b1, as, 3'b000});
    repeat (40) @(negedge sys_clk);
    c0 = cnt;
    repeat (960) @(negedge sys_clk);
    for (int k = 0; k < 6; k++)
      d[k] = cnt[k] - c0[k];
    chk(pll_int_ratio, 4'h8);
    chk_near(d[3], hv ? d[0] / 2 : d[0]);
    chk_near(d[4], ms ? d[0] : (md ? d[2] / 2 : d[2]));
    chk_near(d[5], as ? d[0] : d[1] >> dv);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    logic [7:0] b3, b4, b5, f, rv;
    logic [7:0] addrs [11];
    logic bad;
    {reg_wr, reg_rd, reg_addr, reg_wdata, rx_mode, rx_auto_post_div} = '0;
    {osc_clk_a, pll_clk_a, pll_clk_b, tx_from_rx, tx_subframe} = '0;
    {rx_validity, rx_sample, rx_sample_stb, rx_corrupt, rx_invalid} = '0;
    {mismatches, checks_done, cycles, ph, prev_lv} = '0;
    cnt = '{default: 0};
    void'($urandom(32'h5DF50C83));
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk_defaults();
    addrs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
              8'h08, 8'h09, 8'hFF};
    wr(OFF_ID_HIGH, 8'h5A);
    wr(8'h09, 8'hFF);
    foreach (addrs[k])
    begin
      rd(addrs[k], rv);
      chk(rv, exp_rd(addrs[k]));
    end
    for (int i = 0; i < 8; i++)
    begin
      b3 = 8'($urandom);
      b4 = 8'($urandom);
      b5 = 8'($urandom & 32'h3F);
      rx_mode = i[1];
      rx_auto_post_div = 2'($urandom);
      wr(OFF_FRAC_LOW, b3);
      wr(OFF_FRAC_MID, b4);
      wr(OFF_FRAC_HIGH, b5);
      // Receive mode always keeps the fraction on
      wr(OFF_DIVIDERS, {4'h1, 1'b0, i[0] | i[1], 2'b10});
      @(negedge sys_clk);
      chk(pll_frac_ratio, i[0] | i[1] ? {b5[5:0], b4, b3} : 22'h0);
      chk(pll_post_div, i[1] ? rx_auto_post_div : 2'b10);
    end
    rx_mode = 1'b0;
    // Move int ratio, post divider, fraction mode, aux divider, aux source and pin enable off their defaults so the restore is visible
    wr(OFF_INT_PRE_VAL, 8'h0C);
    wr(OFF_DIVIDERS, 8'h01);
    wr(OFF_SRC_FILL, 8'h00);
    wr(OFF_RESET_ID_LOW, 8'($urandom));
    chk(dev_reset_pulse, 1'b1);
    @(negedge sys_clk);
    chk(dev_reset_pulse, 1'b0);
    chk_defaults();
    for (int i = 0; i < 40; i++)
    begin
      f = 8'($urandom);
      wr(OFF_INT_PRE_VAL, {f[7:5], 5'h08});
      @(negedge sys_clk);
      {rx_validity, tx_subframe, tx_from_rx} = f[2:0];
      @(negedge sys_clk);
      chk(tx_validity, exp_valid(f));
    end
    wr(OFF_SRC_FILL, 8'h08);
    @(negedge sys_clk);
    chk(aux_clk_out_oe_n, 1'b1);
    for (int p = 0; p < 4; p++)
    begin
      wr(OFF_SRC_FILL, {1'b0, p[1], p[0], 5'h18});
      chk(aux_clk_out_oe_n, 1'b0);
      for (int j = 0; j < 14; j++)
      begin
        f = 8'($urandom);
        @(negedge sys_clk);
        rx_sample_stb = (j == 0) | f[0];
        rx_sample = SAMPLE_W'($urandom);
        rx_corrupt = (j > 0) && f[2:1] == 2'b00;
        rx_invalid = (j > 0) & f[3];
        bad = rx_corrupt | (rx_invalid & ~p[1]);
        if (rx_sample_stb && bad)
          exp_d = p[0] ? '0 : last_good;
        else if (rx_sample_stb)
        begin
          exp_d = rx_sample;
          last_good = rx_sample;
        end
        @(negedge sys_clk);
        rx_sample_stb = 1'b0;
        chk(rx_data, exp_d);
      end
    end
    for (int i = 0; i < 8; i++)
      measure(i);
    close_out();
  end
endmodule
